// >>> rtl/xed_pkg.sv
// shared constants for the xor / exchange decode block
package xed_pkg;
	// escape prefix and opcode bytes
	localparam logic [7:0] XED_ESC       = 8'ha5;
	localparam logic [7:0] XED_XR_DIR_A  = 8'h62;
	localparam logic [7:0] XED_XR_RR     = 8'h6c;
	localparam logic [7:0] XED_XR_WW     = 8'h6d;
	localparam logic [7:0] XED_XR_EXT    = 8'h6e;
	localparam logic [6:0] XED_XR_IND    = 7'h33;
	localparam logic [4:0] XED_XR_BANK   = 5'h0d;
	localparam logic [7:0] XED_XC_DIR    = 8'hc5;
	localparam logic [6:0] XED_XC_IND    = 7'h63;
	localparam logic [4:0] XED_XC_BANK   = 5'h19;
	localparam logic [6:0] XED_XD_IND    = 7'h6b;
	localparam logic [7:0] XED_TRAP      = 8'hb9;
	localparam logic [3:0] XED_SUB_D8    = 4'h5;
	localparam logic [3:0] XED_SUB_D16   = 4'h7;
	// trap vector and stack step
	localparam logic [23:0] XED_TRAP_VEC = 24'hff007b;
	localparam logic [15:0] XED_SP_STEP  = 16'h0002;
	// direct addresses of the four i/o port registers
	localparam logic [7:0] XED_PORT0     = 8'h80;
	localparam logic [7:0] XED_PORT1     = 8'h90;
	localparam logic [7:0] XED_PORT2     = 8'ha0;
	localparam logic [7:0] XED_PORT3     = 8'hb0;
	// extra states for port operands, then sp and pc reset values
	localparam logic [1:0] XED_PX_RD     = 2'h1;
	localparam logic [1:0] XED_PX_RMW    = 2'h2;
	localparam logic [15:0] XED_SP_RST   = 16'h0007;
	localparam logic [23:0] XED_PC_RST   = 24'hff0000;
endpackage

// >>> rtl/xed_alu.sv
// bitwise alu for xor, exchange and nibble exchange
`timescale 1ns/1ps
`default_nettype none
module xed_alu (
	input  wire logic [1:0]  op,     // 0 xor, 1 swap, 2 nibble swap
	input  wire logic [15:0] a,      // destination side value
	input  wire logic [15:0] b,      // source side value
	output logic      [15:0] y_a,    // new destination value
	output logic      [15:0] y_b     // new source value (exchange)
);
	// ==========================================
	// combining logic
	always_comb begin
		case (op)
			2'h0: begin
				y_a = a ^ b;     // bit by bit, result to destination only
				y_b = b;
			end
			2'h1: begin
				y_a = b;         // both directions at once
				y_b = a;
			end
			2'h2: begin
				y_a = {a[15:4], b[3:0]};   // upper nibbles kept
				y_b = {b[15:4], a[3:0]};
			end
			default: begin
				y_a = a;
				y_b = b;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> rtl/xed_core.sv
// decode and execute of xor, exchange, nibble exchange and trap
// ==========================================
// Overview of operation
// - byte register xor, source into destination
// - word register xor into destination word
// - direct byte xored with accumulator, written back
// - accumulator xor indirect byte via pointer
// - accumulator xor one of bank registers 0-3 or 7
// - word register xor word at short address
// - word register xor word at long address
// - port operand adds one or two states
// - bitwise, result only into destination
// - binary mode register forms need escape
// - source mode bank/indirect forms need escape
// - trap vector fixed, ignores interrupt enable
// - no interrupt right after trap
`timescale 1ns/1ps
`default_nettype none
module xed_core
	import xed_pkg::*;
(
	input  wire logic        CLOCK,        // 20 MHz core clock
	input  wire logic        SRST,         // synchronous reset, high
	input  wire logic        SOURCE_MODE,  // 1 source opcode mode, 0 binary
	input  wire logic        BYTE_VALID,   // instruction byte offered
	input  wire logic [7:0]  BYTE_IN,      // instruction byte
	output logic             BYTE_READY,   // byte taken this cycle
	input  wire logic        MEM_ACK,      // memory data ready
	input  wire logic [15:0] MEM_RDATA,    // memory read data
	output logic             MEM_REQ,      // memory access request
	output logic             MEM_WE,       // memory write
	output logic             MEM_WORD,     // 16-bit access
	output logic      [23:0] MEM_ADDR,     // memory address
	output logic      [15:0] MEM_WDATA,    // memory write data
	input  wire logic        INT_REQ,      // pending interrupt
	output logic             INT_TAKE,     // interrupt accepted at boundary
	output logic      [7:0]  ACC,          // accumulator
	output logic      [23:0] PC,           // program counter
	output logic      [15:0] SP,           // stack pointer
	output logic             DONE          // instruction boundary pulse
);
	// ==========================================
	// state and storage
	typedef enum logic [8:0] {
		S_OP   = 9'h001,  // fetch opcode
		S_OP2  = 9'h002,  // opcode after escape
		S_B1   = 9'h004,  // operand byte 1
		S_B2   = 9'h008,  // operand byte 2
		S_RD   = 9'h010,  // memory read
		S_EX   = 9'h020,  // compute and write back
		S_WR   = 9'h040,  // memory write
		S_WAIT = 9'h080,  // extra port states
		S_TRAP = 9'h100   // push pc, load fixed vector
	} xed_state_t;
	typedef enum logic [3:0] {
		K_NONE, K_RR, K_WW, K_DIR, K_IND, K_BANK, K_WD8, K_WD16,
		K_XDIR, K_XIND, K_XBANK, K_DIND, K_TRAP
	} xed_kind_t;
	xed_state_t  st_q, st_d;        // sequencer state
	xed_kind_t   kd_q, kd_d;        // decoded instruction
	logic        esc_q, esc_d;      // escape byte seen
	logic [7:0]  op_q, op_d;        // opcode
	logic [7:0]  b1_q, b1_d;        // first operand byte
	logic [7:0]  b2_q, b2_d;        // second operand byte
	logic [15:0] opnd_q, opnd_d;    // fetched memory operand
	logic [1:0]  ws_q, ws_d;        // extra state counter
	logic        noint_q, noint_d;  // interrupt shield after trap
	logic [7:0]  acc_q, acc_d;      // accumulator
	logic [23:0] pc_q, pc_d;        // program counter
	logic [15:0] sp_q, sp_d;        // stack pointer
	logic [7:0]  rf_q [16];         // register file bytes
	logic [7:0]  rf_d [16];
	// ==========================================
	// decode helpers
	logic        is_port;           // direct operand is an i/o port
	logic [1:0]  alu_op;
	logic [15:0] alu_a, alu_b, alu_ya, alu_yb;
	logic [3:0]  rd, rs;            // byte/word register fields
	xed_kind_t   kind;              // decode of a fresh opcode
	logic        want_esc;          // opcode needs escape in this mode
	// extended word forms keep their register field in op_q, since b1_q then holds the address
	assign rd = (kd_q == K_WD8 || kd_q == K_WD16) ? op_q[7:4] : b1_q[7:4];
	assign rs = b1_q[3:0];
	assign is_port = (b1_q == XED_PORT0) | (b1_q == XED_PORT1) |
	                 (b1_q == XED_PORT2) | (b1_q == XED_PORT3);
	// opcode classification; register forms vs bank/indirect forms
	always_comb begin
		kind     = K_NONE;
		want_esc = 1'b0;
		if (BYTE_IN == XED_XR_RR) begin
			kind = K_RR;
			want_esc = ~SOURCE_MODE;
		end else if (BYTE_IN == XED_XR_WW) begin
			kind = K_WW;
			want_esc = ~SOURCE_MODE;
		end else if (BYTE_IN == XED_XR_EXT) begin
			kind = K_WD8;          // refined by sub-opcode later
			want_esc = ~SOURCE_MODE;
		end else if (BYTE_IN == XED_XR_DIR_A) begin
			kind = K_DIR;
		end else if (BYTE_IN[7:1] == XED_XR_IND) begin
			kind = K_IND;
			want_esc = SOURCE_MODE;
		end else if (BYTE_IN[7:3] == XED_XR_BANK) begin
			kind = K_BANK;
			want_esc = SOURCE_MODE;
		end else if (BYTE_IN == XED_XC_DIR) begin
			kind = K_XDIR;
		end else if (BYTE_IN[7:1] == XED_XC_IND) begin
			kind = K_XIND;
			want_esc = SOURCE_MODE;
		end else if (BYTE_IN[7:3] == XED_XC_BANK) begin
			kind = K_XBANK;
			want_esc = SOURCE_MODE;
		end else if (BYTE_IN[7:1] == XED_XD_IND) begin
			kind = K_DIND;
			want_esc = SOURCE_MODE;
		end else if (BYTE_IN == XED_TRAP) begin
			kind = K_TRAP;
			want_esc = ~SOURCE_MODE;
		end
	end
	// ==========================================
	// alu operands
	always_comb begin
		alu_op = 2'h0;
		alu_a  = 16'h0000;
		alu_b  = 16'h0000;
		case (kd_q)
			K_RR:    alu_b = {8'h00, rf_q[rs]};
			K_WW:    alu_b = {rf_q[{rs[3:1], 1'b0}], rf_q[{rs[3:1], 1'b1}]};
			K_WD8, K_WD16: alu_b = opnd_q;
			K_DIR:   alu_b = {8'h00, acc_q};
			default: alu_b = {8'h00, opnd_q[7:0]};
		endcase
		case (kd_q)
			K_RR:    alu_a = {8'h00, rf_q[rd]};
			K_WW, K_WD8, K_WD16: alu_a = {rf_q[{rd[3:1], 1'b0}], rf_q[{rd[3:1], 1'b1}]};
			K_DIR:   alu_a = opnd_q;
			default: alu_a = {8'h00, acc_q};
		endcase
		if (kd_q == K_XDIR || kd_q == K_XIND || kd_q == K_XBANK)
			alu_op = 2'h1;
		else if (kd_q == K_DIND)
			alu_op = 2'h2;
	end
	xed_alu u_alu (
		.op  (alu_op),
		.a   (alu_a),
		.b   (alu_b),
		.y_a (alu_ya),
		.y_b (alu_yb)
	);
	// ==========================================
	// sequencer next state
	always_comb begin
		st_d = st_q;  kd_d = kd_q;  esc_d = esc_q;  op_d = op_q;
		b1_d = b1_q;  b2_d = b2_q;  opnd_d = opnd_q; ws_d = ws_q;
		noint_d = noint_q; acc_d = acc_q; pc_d = pc_q; sp_d = sp_q;
		rf_d = rf_q;
		BYTE_READY = 1'b0; MEM_REQ = 1'b0; MEM_WE = 1'b0; MEM_WORD = 1'b0;
		MEM_ADDR = 24'h000000; MEM_WDATA = 16'h0000; DONE = 1'b0; INT_TAKE = 1'b0;
		case (st_q)
			S_OP, S_OP2: begin
				// interrupts are only taken at a clean boundary
				if (st_q == S_OP && INT_REQ && !noint_q) begin
					INT_TAKE = 1'b1;
				end else if (BYTE_VALID) begin
					BYTE_READY = 1'b1;
					pc_d = pc_q + 24'h000001;
					noint_d = 1'b0;
					if (st_q == S_OP && BYTE_IN == XED_ESC) begin
						st_d = S_OP2;
					end else if (kind != K_NONE && want_esc == (st_q == S_OP2)) begin
						kd_d = kind; op_d = BYTE_IN;
						esc_d = (st_q == S_OP2);
						case (kind)
							K_IND, K_XIND, K_DIND: st_d = S_RD;
							K_BANK, K_XBANK: begin
								opnd_d = {8'h00, rf_q[{1'b0, BYTE_IN[2:0]}]};
								st_d = S_EX;
							end
							K_TRAP: st_d = S_TRAP;
							default: st_d = S_B1;
						endcase
					end else begin
						st_d = S_OP;   // unrecognised: dropped
						DONE = 1'b1;
					end
				end
			end
			S_B1: if (BYTE_VALID) begin
				BYTE_READY = 1'b1; pc_d = pc_q + 24'h000001; b1_d = BYTE_IN;
				if (kd_q == K_WD8) begin
					op_d = BYTE_IN;   // register field and sub-opcode kept
					if (BYTE_IN[3:0] == XED_SUB_D16) kd_d = K_WD16;
					st_d = S_B2;
				end else if (kd_q == K_RR || kd_q == K_WW) st_d = S_EX;
				else st_d = S_RD;   // long address low byte also ends here
			end
			S_B2: if (BYTE_VALID) begin
				BYTE_READY = 1'b1; pc_d = pc_q + 24'h000001;
				if (kd_q == K_WD16) begin
					b2_d = BYTE_IN; st_d = S_B1;
				end else if (op_q[3:0] == XED_SUB_D8) begin
					b1_d = BYTE_IN; st_d = S_RD;
				end else begin
					st_d = S_OP; DONE = 1'b1;   // other extended forms not handled here
				end
			end
			S_RD: begin
				MEM_REQ = 1'b1;
				MEM_WORD = (kd_q == K_WD8 || kd_q == K_WD16);
				MEM_ADDR = (kd_q == K_IND || kd_q == K_XIND || kd_q == K_DIND)
					? {16'h0000, rf_q[{3'h0, op_q[0]}]} : {8'h00, b2_q, b1_q};
				if (kd_q == K_WD8 || kd_q == K_DIR || kd_q == K_XDIR)
					MEM_ADDR = {16'h0000, b1_q};
				if (MEM_ACK) begin
					opnd_d = MEM_RDATA;
					ws_d = 2'h0;
					if ((kd_q == K_DIR || kd_q == K_XDIR) && is_port) begin
						ws_d = XED_PX_RMW;
						st_d = S_WAIT;
					end else if (kd_q == K_WD8 && is_port) begin
						ws_d = XED_PX_RD;
						st_d = S_WAIT;
					end else st_d = S_EX;
				end
			end
			S_WAIT: begin
				ws_d = ws_q - 2'h1;
				if (ws_q == 2'h1) st_d = S_EX;
			end
			S_EX: begin
				st_d = S_OP; DONE = 1'b1;
				case (kd_q)
					K_RR: rf_d[rd] = alu_ya[7:0];
					K_WW, K_WD8, K_WD16: begin
						rf_d[{rd[3:1], 1'b0}] = alu_ya[15:8];
						rf_d[{rd[3:1], 1'b1}] = alu_ya[7:0];
					end
					K_DIR, K_XDIR, K_XIND, K_DIND: begin
						if (kd_q != K_DIR) acc_d = alu_ya[7:0];
						opnd_d = (kd_q == K_DIR) ? alu_ya : alu_yb;
						st_d = S_WR; DONE = 1'b0;
					end
					K_XBANK: begin
						acc_d = alu_ya[7:0];
						rf_d[{1'b0, op_q[2:0]}] = alu_yb[7:0];
					end
					default: acc_d = alu_ya[7:0];
				endcase
			end
			S_WR: begin
				MEM_REQ = 1'b1; MEM_WE = 1'b1; MEM_WDATA = {8'h00, opnd_q[7:0]};
				MEM_ADDR = (kd_q == K_DIR || kd_q == K_XDIR)
					? {16'h0000, b1_q} : {16'h0000, rf_q[{3'h0, op_q[0]}]};
				if (MEM_ACK) begin
					st_d = S_OP; DONE = 1'b1;
				end
			end
			S_TRAP: begin
				// push pc then vector; interrupt enable plays no part
				MEM_REQ = 1'b1; MEM_WE = 1'b1; MEM_WORD = 1'b1;
				MEM_ADDR = {8'h00, sp_q - XED_SP_STEP};
				MEM_WDATA = pc_q[15:0];
				if (MEM_ACK) begin
					sp_d = sp_q - XED_SP_STEP;
					pc_d = XED_TRAP_VEC;
					noint_d = 1'b1;
					st_d = S_OP; DONE = 1'b1;
				end
			end
			default: st_d = S_OP;
		endcase
	end
	// ==========================================
	// registers
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			st_q <= S_OP; kd_q <= K_NONE; esc_q <= 1'b0; op_q <= 8'h00;
			b1_q <= 8'h00; b2_q <= 8'h00; opnd_q <= 16'h0000; ws_q <= 2'h0;
			noint_q <= 1'b0; acc_q <= 8'h00; pc_q <= XED_PC_RST; sp_q <= XED_SP_RST;
			for (int i = 0; i < 16; i++) rf_q[i] <= 8'h00;
		end else begin
			st_q <= st_d; kd_q <= kd_d; esc_q <= esc_d; op_q <= op_d;
			b1_q <= b1_d; b2_q <= b2_d; opnd_q <= opnd_d; ws_q <= ws_d;
			noint_q <= noint_d; acc_q <= acc_d; pc_q <= pc_d; sp_q <= sp_d;
			rf_q <= rf_d;
		end
	end
	assign ACC = acc_q;
	assign PC  = pc_q;
	assign SP  = sp_q;
	// ==========================================
	// checks
	property p_trap_sp;
		@(posedge CLOCK) disable iff (SRST)
		(st_q == S_TRAP && MEM_ACK) |=> (sp_q == $past(sp_q) - XED_SP_STEP) && (pc_q == XED_TRAP_VEC);
	endproperty
	a_trap_sp: assert property (p_trap_sp) else $error("trap did not vector");
	property p_noint;
		@(posedge CLOCK) disable iff (SRST)
		(st_q == S_TRAP && MEM_ACK) |=> !INT_TAKE;
	endproperty
	a_noint: assert property (p_noint) else $error("interrupt after trap");
	property p_port_wait;
		@(posedge CLOCK) disable iff (SRST)
		(st_q == S_RD && MEM_ACK && kd_q == K_DIR && is_port) |=> (st_q == S_WAIT) [*2] ##1 (st_q == S_EX);
	endproperty
	a_port_wait: assert property (p_port_wait) else $error("port extra states wrong");
	property p_xor_acc;
		@(posedge CLOCK) disable iff (SRST)
		(st_q == S_EX && kd_q == K_BANK) |=> acc_q == ($past(acc_q) ^ $past(opnd_q[7:0]));
	endproperty
	a_xor_acc: assert property (p_xor_acc) else $error("bank xor wrong");
	sequence s_one_wait;
		(st_q == S_WAIT) ##1 (st_q == S_EX);
	endsequence
	property p_rd_wait;
		@(posedge CLOCK) disable iff (SRST)
		(st_q == S_RD && MEM_ACK && kd_q == K_WD8 && is_port) |=> s_one_wait;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("port read extra state wrong");
	property p_nibble;
		@(posedge CLOCK) disable iff (SRST)
		(st_q == S_EX && kd_q == K_DIND) |=>
			(acc_q[7:4] == $past(acc_q[7:4])) && (acc_q[3:0] == $past(opnd_q[3:0]));
	endproperty
	a_nibble: assert property (p_nibble) else $error("nibble exchange wrong");
endmodule
`default_nettype wire

// >>> verification/xed_core_tb.sv
// self-checking testbench for the xor / exchange decode block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import xed_pkg::*;
;
	// ==========================================
	// signals
	logic        CLOCK;        // 50 ns core clock
	logic        SRST;         // synchronous reset
	logic        SOURCE_MODE;  // opcode map select
	logic        BYTE_VALID;   // byte offered
	logic [7:0]  BYTE_IN;      // instruction byte
	logic        BYTE_READY;   // byte taken
	logic        MEM_ACK;      // memory answer
	logic [15:0] MEM_RDATA;    // memory read data
	logic        MEM_REQ;      // memory request
	logic        MEM_WE;       // memory write
	logic        MEM_WORD;     // word access
	logic [23:0] MEM_ADDR;     // memory address
	logic [15:0] MEM_WDATA;    // memory write data
	logic        INT_REQ;      // pending interrupt
	logic        INT_TAKE;     // interrupt accepted
	logic [7:0]  ACC;          // accumulator
	logic [23:0] PC;           // program counter
	logic [15:0] SP;           // stack pointer
	logic        DONE;         // instruction end
	logic [7:0]  mem [256];    // data memory seen by the block
	logic [7:0]  a;            // responder address
	logic        done_seen;    // done flag since last clear
	logic        int_seen;     // interrupt flag since last clear
	int          failures;     // mismatches
	int          checked;      // comparisons
	int          lat;          // cycles from last byte to done
	int          l1;           // reference latency
	// rows: mode, byte count, five bytes, acc, checked address, byte there
	logic [71:0] rows [18] = '{
		72'h02_c530000000_3c_30_00, 72'h01_6600000000_33_00_0f, 72'h01_ca00000000_00_30_00,
		72'h01_6a00000000_33_30_00, 72'h02_6230000000_33_30_33, 72'h03_a56c320000_33_30_33,
		72'h01_6b00000000_00_30_33, 72'h11_6b00000000_00_30_33, 72'h12_a56b000000_33_30_33,
		72'h12_a5d6000000_3f_00_03, 72'h12_6c23000000_3f_00_03, 72'h12_a5ca000000_00_00_03,
		72'h04_a56e454000_00_40_12, 72'h01_cd00000000_34_40_12, 72'h05_a56e470040_34_41_34,
		72'h01_cc00000000_00_41_34, 72'h03_a56d240000_00_41_34, 72'h01_cb00000000_07_41_34};

	xed_core dut_u (.CLOCK(CLOCK), .SRST(SRST), .SOURCE_MODE(SOURCE_MODE), .BYTE_VALID(BYTE_VALID),
		.BYTE_IN(BYTE_IN), .BYTE_READY(BYTE_READY), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
		.MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_WORD(MEM_WORD), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .INT_REQ(INT_REQ), .INT_TAKE(INT_TAKE), .ACC(ACC), .PC(PC), .SP(SP),
		.DONE(DONE));

	// ==========================================
	// clock and watchers
	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end
	// pulses are caught mid-cycle where combinational outputs have settled
	always @(negedge CLOCK) begin
		if (DONE === 1'b1) done_seen = 1'b1;
		if (INT_TAKE === 1'b1) int_seen = 1'b1;
	end
	// memory answers 2 ns into the first cycle of a request; released data is inverted every idle cycle
	always @(posedge CLOCK) begin
		#2;
		if (MEM_REQ === 1'b1 && MEM_ACK !== 1'b1) begin
			MEM_ACK = 1'b1;
			a = MEM_ADDR[7:0];
			MEM_RDATA = MEM_WORD ? {mem[a], mem[a + 8'h01]} : {8'h00, mem[a]};
			if (MEM_WE === 1'b1 && MEM_WORD === 1'b1) begin
				mem[a] = MEM_WDATA[15:8];
				mem[a + 8'h01] = MEM_WDATA[7:0];
			end else if (MEM_WE === 1'b1) begin
				mem[a] = MEM_WDATA[7:0];
			end
		end else begin
			MEM_ACK = 1'b0;
			MEM_RDATA = ~MEM_RDATA;
		end
	end

	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// offer one byte, held until the edge at which ready is high
	task automatic send(input logic [7:0] b);
		int k;
		BYTE_VALID = 1'b1;
		BYTE_IN = b;
		k = 0;
		@(negedge CLOCK);
		while (BYTE_READY !== 1'b1 && k < 50) begin
			@(negedge CLOCK);
			k++;
		end
		if (k == 50) begin
			failures++;
			test_done();
		end
		@(posedge CLOCK);
		#2;
	endtask

	// feed one whole instruction and wait for its end
	task automatic run(input logic mode, input int n, input logic [39:0] bytes);
		SOURCE_MODE = mode;
		done_seen = 1'b0;
		for (int i = 0; i < n; i++) send(bytes[39 - 8 * i -: 8]);
		BYTE_VALID = 1'b0;
		lat = 0;
		while (done_seen !== 1'b1 && lat < 60) begin
			@(posedge CLOCK);
			lat++;
		end
		if (lat == 60) begin
			failures++;
			test_done();
		end
		#2;
	endtask

	// ==========================================
	// main sequence
	initial begin
		SRST = 1'b1;
		SOURCE_MODE = 1'b0;
		BYTE_VALID = 1'b0;
		BYTE_IN = 8'h00;
		MEM_ACK = 1'b0;
		MEM_RDATA = 16'h0000;
		INT_REQ = 1'b0;
		done_seen = 1'b0;
		int_seen = 1'b0;
		failures = 0;
		checked = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		mem[8'h00] = 8'h0f;
		mem[8'h30] = 8'h3c;
		mem[8'h40] = 8'h12;
		mem[8'h41] = 8'h34;
		mem[8'h80] = 8'h81;
		repeat (16) @(posedge CLOCK);
		#2;
		SRST = 1'b0;
		chk(32'(ACC), 32'h0);
		chk(32'(PC), 32'(XED_PC_RST));
		chk(32'(SP), 32'(XED_SP_RST));
		// ordinary cases: after each row acc and one memory byte are checked
		foreach (rows[r]) begin
			run(rows[r][71:68] != 4'h0, int'(rows[r][67:64]), rows[r][63:24]);
			chk(32'(ACC), 32'(rows[r][23:16]));
			chk(32'(mem[rows[r][15:8]]), 32'(rows[r][7:0]));
		end
		// port operands stretch a read form by one state and a write-back form by two
		run(1'b0, 4, 40'ha56e453000);
		l1 = lat;
		run(1'b0, 4, 40'ha56e458000);
		chk(32'(lat - l1), 32'h1);
		chk(32'(ACC), 32'h07);
		run(1'b0, 2, 40'h6230000000);
		l1 = lat;
		run(1'b0, 2, 40'h6280000000);
		chk(32'(lat - l1), 32'h2);
		chk(32'(mem[8'h80]), 32'h86);
		// trap: pending interrupt raised mid-trap must wait one boundary
		SOURCE_MODE = 1'b0;
		l1 = int'(PC[15:0]);
		done_seen = 1'b0;
		send(XED_ESC);
		send(XED_TRAP);
		BYTE_VALID = 1'b0;
		INT_REQ = 1'b1;
		int_seen = 1'b0;
		lat = 0;
		while (done_seen !== 1'b1 && lat < 60) begin
			@(posedge CLOCK);
			lat++;
		end
		@(posedge CLOCK);
		#2;
		chk(32'(done_seen), 32'h1);
		chk(32'(int_seen), 32'h0);
		chk(32'(PC), 32'(XED_TRAP_VEC));
		chk(32'(SP), 32'(XED_SP_RST - XED_SP_STEP));
		chk(32'({mem[8'h05], mem[8'h06]}), 32'((l1 + 2) & 32'h0000ffff));
		// the next boundary is open again
		run(1'b0, 1, 40'h6b00000000);
		repeat (4) @(posedge CLOCK);
		chk(32'(int_seen), 32'h1);
		INT_REQ = 1'b0;
		test_done();
	end
endmodule
`default_nettype wire
